// >>> design/filter_config_pkg.sv
// constants for the fine gain and programmable filter configuration block
package filter_config_pkg;

  // ==========================================================
  // serial configuration frame
  localparam int ADDR_WIDTH      = 15;
  localparam int HEADER_BITS     = 16;
  localparam int DATA_BITS       = 8;
  localparam int HDR_CNT_WIDTH   = 5;
  localparam int BIT_CNT_WIDTH   = 3;
  localparam logic [4:0] HDR_LAST_BIT  = 5'hF;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam int HDR_RW_BIT      = 15;

  // ==========================================================
  // register byte addresses
  localparam logic [14:0] ADDR_TRIM_B0_TWO = 15'h0352;
  localparam logic [14:0] ADDR_TRIM_B1_TWO = 15'h0353;
  localparam logic [14:0] ADDR_TRIM_A0_ONE = 15'h0354;
  localparam logic [14:0] ADDR_TRIM_A1_ONE = 15'h0355;
  localparam logic [14:0] ADDR_TRIM_B0_ONE = 15'h0356;
  localparam logic [14:0] ADDR_TRIM_B1_ONE = 15'h0357;
  localparam logic [14:0] ADDR_FILTER_CFG  = 15'h0400;
  localparam logic [14:0] ADDR_TAP0_A_LO   = 15'h0418;
  localparam logic [14:0] ADDR_TAP0_A_HI   = 15'h0419;
  localparam logic [14:0] ADDR_STEP        = 15'h0001;

  // ==========================================================
  // field layout and reset values
  localparam int TRIM_WIDTH      = 5;
  localparam int TRIM_MSB        = 4;
  localparam logic [7:0] TRIM_RESET     = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [15:0] TAP0_RESET    = 16'h0000;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
  localparam int CFG_SHARE_BIT   = 6;
  localparam int CFG_MERGE_BIT   = 5;
  localparam int CFG_WEIGHT_MSB  = 4;
  localparam int CFG_WEIGHT_LSB  = 2;
  localparam int CFG_MODE_MSB    = 1;
  localparam int CFG_MODE_LSB    = 0;
  localparam int COEF_WIDTH      = 12;
  localparam int COEF_MSB        = 11;
  localparam int TAP0_RSVD_MSB   = 15;
  localparam int TAP0_RSVD_LSB   = 12;
  localparam int TAP0_HI_MSB     = 15;
  localparam int TAP0_HI_LSB     = 8;

  // ==========================================================
  // filter shape
  localparam int TAP_COUNT       = 9;
  localparam int CENTER_TAP      = 4;
  localparam int CENTER_WIDTH    = 18;
  localparam int WEIGHT_BIAS     = 16;
  localparam logic [2:0] WEIGHT_MAX_LEGAL = 3'h6;

  typedef enum logic [1:0] {
    FILTER_OFF   = 2'h0,
    FILTER_RSVD1 = 2'h1,
    FILTER_ON    = 2'h2,
    FILTER_RSVD3 = 2'h3
  } filter_mode_t;

  // lsb exponent of a tap: side taps 2^(w-16), center tap unscaled
  function automatic logic signed [5:0] tap_lsb_exp(input int tap,
                                                    input logic [2:0] w);
    if (tap == CENTER_TAP) begin
      return 6'sh00;
    end
    return $signed({3'h0, w}) - 6'sd16;
  endfunction

endpackage

// >>> design/config_serial_port.sv
// serial configuration port: frame decode into byte register accesses
`timescale 1ns/100ps
module config_serial_port
  import filter_config_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // serial pins
  input  wire logic                  sclk,
  input  wire logic                  sdi,
  input  wire logic                  csn,
  output logic                       sdo,
  output logic                       sdoOe,
  // register side
  output logic [ADDR_WIDTH-1:0]      regAddr,
  output logic [7:0]                 regWrData,
  output logic                       regWrStrobe,
  input  wire logic [7:0]            regRdData
);

  logic                      sclkPrev_reg;
  logic [HDR_CNT_WIDTH-1:0]  hdrCnt_reg;
  logic [BIT_CNT_WIDTH-1:0]  bitCnt_reg;
  logic                      inData_reg;
  logic                      isRead_reg;
  logic [HEADER_BITS-1:0]    shiftIn_reg;
  logic [7:0]                byteIn_reg;
  logic [ADDR_WIDTH-1:0]     addr_reg;
  logic [7:0]                sdoShift_reg;
  logic                      loadPending_reg;
  logic                      wrStrobe_reg;
  logic [7:0]                wrData_reg;
  logic                      rise;
  logic                      hdrDone;
  logic                      byteDone;

  // inputs are taken as synchronous to clk
  assign rise     = sclk & ~sclkPrev_reg & ~csn;
  assign hdrDone  = rise & ~inData_reg & (hdrCnt_reg == HDR_LAST_BIT);
  assign byteDone = rise & inData_reg & (bitCnt_reg == BYTE_LAST_BIT);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkPrev_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= sclk;
    end
  end

  // ==========================================================
  // frame sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hdrCnt_reg  <= '0;
      bitCnt_reg  <= '0;
      inData_reg  <= 1'b0;
      isRead_reg  <= 1'b0;
      shiftIn_reg <= '0;
      byteIn_reg  <= 8'h00;
      addr_reg    <= '0;
    end else if (csn) begin
      hdrCnt_reg <= '0;
      bitCnt_reg <= '0;
      inData_reg <= 1'b0;
      isRead_reg <= 1'b0;
    end else if (hdrDone) begin
      inData_reg <= 1'b1;
      isRead_reg <= shiftIn_reg[HDR_RW_BIT-1];
      addr_reg   <= {shiftIn_reg[ADDR_WIDTH-2:0], sdi};
    end else if (rise && !inData_reg) begin
      shiftIn_reg <= {shiftIn_reg[HEADER_BITS-2:0], sdi};
      hdrCnt_reg  <= hdrCnt_reg + 5'h1;
    end else if (rise) begin
      byteIn_reg <= {byteIn_reg[6:0], sdi};
      bitCnt_reg <= bitCnt_reg + 3'h1;
      // streaming: next byte goes to the next address
      if (byteDone) begin
        addr_reg <= addr_reg + ADDR_STEP;
      end
    end
  end

  // ==========================================================
  // write strobe, one cycle per completed byte of a write frame; none on reads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrStrobe_reg <= 1'b0;
      wrData_reg   <= 8'h00;
    end else begin
      wrStrobe_reg <= byteDone & ~isRead_reg;
      if (byteDone) begin
        wrData_reg <= {byteIn_reg[6:0], sdi};
      end
    end
  end

  // ==========================================================
  // read shifter, loaded a cycle after the address settles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loadPending_reg <= 1'b0;
      sdoShift_reg    <= 8'h00;
    end else begin
      loadPending_reg <= hdrDone ? shiftIn_reg[HDR_RW_BIT-1]
                                 : (byteDone & isRead_reg);
      if (loadPending_reg) begin
        sdoShift_reg <= regRdData;
      end else if (rise && inData_reg) begin
        sdoShift_reg <= {sdoShift_reg[6:0], 1'b0};
      end
    end
  end

  // write address trails the increment, so present the captured one
  logic [ADDR_WIDTH-1:0] wrAddr_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrAddr_reg <= '0;
    end else if (byteDone) begin
      wrAddr_reg <= addr_reg;
    end
  end

  assign regAddr     = wrStrobe_reg ? wrAddr_reg : addr_reg;
  assign regWrData   = wrData_reg;
  assign regWrStrobe = wrStrobe_reg;
  assign sdo         = sdoShift_reg[7];
  assign sdoOe       = ~csn & inData_reg & isRead_reg;

endmodule

// >>> design/output_path_select.sv
// chooses filtered or raw converter samples for the output path
`timescale 1ns/100ps
module output_path_select #(
  parameter int SAMPLE_WIDTH = 12
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // control
  input  wire logic                    filterOn,
  // samples
  input  wire logic [SAMPLE_WIDTH-1:0] rawA,
  input  wire logic [SAMPLE_WIDTH-1:0] rawB,
  input  wire logic [SAMPLE_WIDTH-1:0] filteredA,
  input  wire logic [SAMPLE_WIDTH-1:0] filteredB,
  output logic [SAMPLE_WIDTH-1:0]      outA,
  output logic [SAMPLE_WIDTH-1:0]      outB
);

  // registered so both paths see the same one-cycle latency
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outA <= '0;
      outB <= '0;
    end else begin
      outA <= filterOn ? filteredA : rawA;
      outB <= filterOn ? filteredB : rawB;
    end
  end

endmodule

// >>> design/fine_gain_and_pfir_config_regs.sv
// fine gain trim and programmable filter configuration registers
//
// Function
// - two-channel mode: 0x352 bits 4:0 trim converter B bank 0.
// - two-channel mode: 0x353 bits 4:0 trim converter B bank 1.
// - one-channel mode: A bank0/bank1 trims from 0x354 and 0x355.
// - one-channel mode: B bank0/bank1 trims from 0x356 and 0x357.
// - trim defaults come from fuses; bits 7:5 reserved read/write, zero.
// - share bit 6 set: channel B uses channel A coefficients.
// - merge bit 5 set: both filters form one interleaved filter.
// - bits 4:2 set side tap lsb weight to 2^(field-16).
// - mode bits 1:0: 0 disables, 2 enables, 1 and 3 reserved.
// - 0x418 bits 11:0 hold signed first tap of filter A or merged.
// - coefficient readback returns msb as zero; filter uses written value.
// - tap0 bits 15:12 reserved read/write zero; config resets to zero.
// - nine taps; fifth is 18-bit center tap, not weight-scaled.
`timescale 1ns/100ps
module fine_gain_and_pfir_config_regs
  import filter_config_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // configuration port pins
  input  wire logic                      sclk,
  input  wire logic                      sdi,
  input  wire logic                      csn,
  output logic                           sdo,
  output logic                           sdoOe,
  // operating mode
  input  wire logic                      singleChannel,
  // fuse store
  input  wire logic                      fuseLoad,
  input  wire logic [TRIM_WIDTH-1:0]     fuseTrimB0Two,
  input  wire logic [TRIM_WIDTH-1:0]     fuseTrimB1Two,
  input  wire logic [TRIM_WIDTH-1:0]     fuseTrimA0One,
  input  wire logic [TRIM_WIDTH-1:0]     fuseTrimA1One,
  input  wire logic [TRIM_WIDTH-1:0]     fuseTrimB0One,
  input  wire logic [TRIM_WIDTH-1:0]     fuseTrimB1One,
  // two-channel A trims held elsewhere
  input  wire logic [TRIM_WIDTH-1:0]     trimA0TwoIn,
  input  wire logic [TRIM_WIDTH-1:0]     trimA1TwoIn,
  // trims applied to the converter cores
  output logic [TRIM_WIDTH-1:0]          gainTrimA0,
  output logic [TRIM_WIDTH-1:0]          gainTrimA1,
  output logic [TRIM_WIDTH-1:0]          gainTrimB0,
  output logic [TRIM_WIDTH-1:0]          gainTrimB1,
  // filter controls
  input  wire logic [COEF_WIDTH-1:0]     coefTap0BOwn,
  output logic                           filterEnable,
  output logic                           filterShare,
  output logic                           filterMerged,
  output logic signed [5:0]              sideLsbExp,
  output logic signed [5:0]              centerLsbExp,
  output logic [COEF_WIDTH-1:0]          coefTap0A,
  output logic [COEF_WIDTH-1:0]          coefTap0B,
  // sample path
  input  wire logic [SAMPLE_WIDTH-1:0]   rawA,
  input  wire logic [SAMPLE_WIDTH-1:0]   rawB,
  input  wire logic [SAMPLE_WIDTH-1:0]   filteredA,
  input  wire logic [SAMPLE_WIDTH-1:0]   filteredB,
  output logic [SAMPLE_WIDTH-1:0]        outA,
  output logic [SAMPLE_WIDTH-1:0]        outB
);

  // ==========================================================
  // register storage
  logic [7:0]               trimB0Two_reg;
  logic [7:0]               trimB1Two_reg;
  logic [7:0]               trimA0One_reg;
  logic [7:0]               trimA1One_reg;
  logic [7:0]               trimB0One_reg;
  logic [7:0]               trimB1One_reg;
  logic [7:0]               filterCfg_reg;
  logic [15:0]              tap0A_reg;
  logic [ADDR_WIDTH-1:0]    regAddr;
  logic [7:0]               regWrData;
  logic                     regWrStrobe;
  logic [7:0]               regRdData;
  filter_mode_t             modeSel;
  logic [2:0]               weightField;
  logic                     filterOn;

  // ==========================================================
  // configuration port
  config_serial_port u_port (
    .clk         (clk),
    .resetn      (resetn),
    .sclk        (sclk),
    .sdi         (sdi),
    .csn         (csn),
    .sdo         (sdo),
    .sdoOe       (sdoOe),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regWrStrobe (regWrStrobe),
    .regRdData   (regRdData)
  );

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a);
    return regWrStrobe && (regAddr == a);
  endfunction

  // fuse copy lands in the trim field; a same-cycle write wins
  function automatic logic [7:0] trim_next(input logic [7:0] cur,
                                           input logic [4:0] fuse,
                                           input logic       wr);
    if (wr) begin
      return regWrData;
    end
    if (fuseLoad) begin
      return {cur[7:TRIM_WIDTH], fuse};
    end
    return cur;
  endfunction

  // ==========================================================
  // fine gain trims
  // fuse-loaded defaults
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trimB0Two_reg <= TRIM_RESET;
      trimB1Two_reg <= TRIM_RESET;
      trimA0One_reg <= TRIM_RESET;
      trimA1One_reg <= TRIM_RESET;
      trimB0One_reg <= TRIM_RESET;
      trimB1One_reg <= TRIM_RESET;
    end else begin
      trimB0Two_reg <= trim_next(trimB0Two_reg, fuseTrimB0Two,
                                 hit(ADDR_TRIM_B0_TWO));
      trimB1Two_reg <= trim_next(trimB1Two_reg, fuseTrimB1Two,
                                 hit(ADDR_TRIM_B1_TWO));
      trimA0One_reg <= trim_next(trimA0One_reg, fuseTrimA0One,
                                 hit(ADDR_TRIM_A0_ONE));
      trimA1One_reg <= trim_next(trimA1One_reg, fuseTrimA1One,
                                 hit(ADDR_TRIM_A1_ONE));
      trimB0One_reg <= trim_next(trimB0One_reg, fuseTrimB0One,
                                 hit(ADDR_TRIM_B0_ONE));
      trimB1One_reg <= trim_next(trimB1One_reg, fuseTrimB1One,
                                 hit(ADDR_TRIM_B1_ONE));
    end
  end

  // ==========================================================
  // filter configuration and first coefficient
  // zero reset, reserved bits kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filterCfg_reg <= CFG_RESET;
    end else if (hit(ADDR_FILTER_CFG)) begin
      filterCfg_reg <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tap0A_reg <= TAP0_RESET;
    end else if (hit(ADDR_TAP0_A_LO)) begin
      tap0A_reg[7:0] <= regWrData;
    end else if (hit(ADDR_TAP0_A_HI)) begin
      tap0A_reg[TAP0_HI_MSB:TAP0_HI_LSB] <= regWrData;
    end
  end

  // ==========================================================
  // readback
  always_comb begin
    case (regAddr)
      ADDR_TRIM_B0_TWO: regRdData = trimB0Two_reg;
      ADDR_TRIM_B1_TWO: regRdData = trimB1Two_reg;
      ADDR_TRIM_A0_ONE: regRdData = trimA0One_reg;
      ADDR_TRIM_A1_ONE: regRdData = trimA1One_reg;
      ADDR_TRIM_B0_ONE: regRdData = trimB0One_reg;
      ADDR_TRIM_B1_ONE: regRdData = trimB1One_reg;
      ADDR_FILTER_CFG:  regRdData = filterCfg_reg;
      ADDR_TAP0_A_LO:   regRdData = tap0A_reg[7:0];
      ADDR_TAP0_A_HI:   regRdData = {tap0A_reg[TAP0_RSVD_MSB:TAP0_RSVD_LSB],
                                     1'b0, tap0A_reg[COEF_MSB-1:8]};
      default:          regRdData = READ_UNMAPPED;
    endcase
  end

  // ==========================================================
  // trims to the converter cores
  // B banks, then A banks; singleChannel picks the one- or two-channel source
  assign gainTrimB0 = singleChannel ? trimB0One_reg[TRIM_MSB:0]
                                    : trimB0Two_reg[TRIM_MSB:0];
  assign gainTrimB1 = singleChannel ? trimB1One_reg[TRIM_MSB:0]
                                    : trimB1Two_reg[TRIM_MSB:0];
  assign gainTrimA0 = singleChannel ? trimA0One_reg[TRIM_MSB:0]
                                    : trimA0TwoIn;
  assign gainTrimA1 = singleChannel ? trimA1One_reg[TRIM_MSB:0]
                                    : trimA1TwoIn;
  // covered by the B selects above

  // ==========================================================
  // filter controls
  // only code 2 enables; reserved codes stay off
  assign modeSel     = filter_mode_t'(filterCfg_reg[CFG_MODE_MSB:CFG_MODE_LSB]);
  assign filterOn    = (modeSel == FILTER_ON);
  assign weightField = filterCfg_reg[CFG_WEIGHT_MSB:CFG_WEIGHT_LSB];

  // share selects A set for B
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filterEnable <= 1'b0;
      filterShare  <= 1'b0;
      filterMerged <= 1'b0;
      sideLsbExp   <= 6'sh00;
      centerLsbExp <= 6'sh00;
      coefTap0A    <= '0;
      coefTap0B    <= '0;
    end else begin
      filterEnable <= filterOn;
      filterShare  <= filterOn & filterCfg_reg[CFG_SHARE_BIT];
      filterMerged <= filterOn & filterCfg_reg[CFG_MERGE_BIT];
      sideLsbExp   <= filterOn ? tap_lsb_exp(0, weightField) : 6'sh00;
      centerLsbExp <= tap_lsb_exp(CENTER_TAP, weightField);
      // written msb is used even though it reads back as zero
      coefTap0A    <= filterOn ? tap0A_reg[COEF_MSB:0] : '0;
      coefTap0B    <= !filterOn ? '0 :
                      filterCfg_reg[CFG_SHARE_BIT] ? tap0A_reg[COEF_MSB:0]
                                                   : coefTap0BOwn;
    end
  end

  // ==========================================================
  // sample output path
  // raw samples when disabled
  output_path_select #(
    .SAMPLE_WIDTH (SAMPLE_WIDTH)
  ) u_path (
    .clk       (clk),
    .resetn    (resetn),
    .filterOn  (filterOn),
    .rawA      (rawA),
    .rawB      (rawB),
    .filteredA (filteredA),
    .filteredB (filteredB),
    .outA      (outA),
    .outB      (outB)
  );

endmodule

// >>> testbench/fine_gain_and_pfir_config_regs_sva.sv
// checker for the gain trim and filter configuration outputs
`timescale 1ns/100ps
module fine_gain_and_pfir_config_regs_sva
  import filter_config_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // controls
  input wire logic                    singleChannel,
  input wire logic                    fuseLoad,
  input wire logic                    csn,
  input wire logic [COEF_WIDTH-1:0]   coefTap0BOwn,
  // observed outputs
  input wire logic [TRIM_WIDTH-1:0]   gainTrimB0,
  input wire logic [TRIM_WIDTH-1:0]   gainTrimB1,
  input wire logic                    filterEnable,
  input wire logic                    filterShare,
  input wire logic                    filterMerged,
  input wire logic signed [5:0]       sideLsbExp,
  input wire logic signed [5:0]       centerLsbExp,
  input wire logic [COEF_WIDTH-1:0]   coefTap0A,
  input wire logic [COEF_WIDTH-1:0]   coefTap0B,
  // sample path
  input wire logic [SAMPLE_WIDTH-1:0] rawA,
  input wire logic [SAMPLE_WIDTH-1:0] rawB,
  input wire logic [SAMPLE_WIDTH-1:0] filteredA,
  input wire logic [SAMPLE_WIDTH-1:0] filteredB,
  input wire logic [SAMPLE_WIDTH-1:0] outA,
  input wire logic [SAMPLE_WIDTH-1:0] outB
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // first edge after reset still sees reset-time outputs
  a_out_a_select: assert property ($past(resetn) |->
    outA == (filterEnable ? $past(filteredA) : $past(rawA)))
    else $error("output A picks the wrong sample source");
  a_out_b_select: assert property ($past(resetn) |->
    outB == (filterEnable ? $past(filteredB) : $past(rawB)))
    else $error("output B picks the wrong sample source");
  a_disabled_clear: assert property (!filterEnable |->
    !filterShare && !filterMerged && sideLsbExp == 0
    && coefTap0A == 0 && coefTap0B == 0)
    else $error("filter settings leak while disabled");
  a_share_uses_a: assert property (filterShare |->
    coefTap0B == coefTap0A)
    else $error("shared channel B tap differs from channel A");
  a_own_b_tap: assert property (
    $past(resetn) && filterEnable && !filterShare
    |-> coefTap0B == $past(coefTap0BOwn))
    else $error("channel B does not use its own tap");
  a_merge_enabled: assert property (filterMerged |-> filterEnable)
    else $error("merge reported with filter disabled");
  a_side_range: assert property (filterEnable |->
    sideLsbExp >= -16 && sideLsbExp <= -9)
    else $error("side weight exponent out of range");
  a_center_fixed: assert property (centerLsbExp == 6'sh00)
    else $error("center tap exponent is scaled");
  a_trim_quiet: assert property (
    $past(resetn) && $past(csn) && csn && !$past(fuseLoad)
    && $stable(singleChannel)
    |-> $stable(gainTrimB0) && $stable(gainTrimB1))
    else $error("trim changed with no write or fuse load");
endmodule

bind fine_gain_and_pfir_config_regs fine_gain_and_pfir_config_regs_sva #(
  .SAMPLE_WIDTH(SAMPLE_WIDTH)
) u_sva (
  .clk(clk), .resetn(resetn), .singleChannel(singleChannel),
  .fuseLoad(fuseLoad), .csn(csn), .coefTap0BOwn(coefTap0BOwn),
  .gainTrimB0(gainTrimB0), .gainTrimB1(gainTrimB1),
  .filterEnable(filterEnable), .filterShare(filterShare),
  .filterMerged(filterMerged), .sideLsbExp(sideLsbExp),
  .centerLsbExp(centerLsbExp), .coefTap0A(coefTap0A),
  .coefTap0B(coefTap0B), .rawA(rawA), .rawB(rawB),
  .filteredA(filteredA), .filteredB(filteredB), .outA(outA), .outB(outB)
);

// >>> testbench/tb_top.sv
// self-checking bench for the gain trim and filter configuration registers
`timescale 1ns/100ps
module tb_top
  import filter_config_pkg::*;
;
  logic              clk = 0, resetn = 0, sclk = 0, sdi = 0, csn = 1;
  logic              singleChannel = 0, fuseLoad = 0;
  logic [4:0]        fz [6];
  logic [4:0]        trimA0TwoIn, trimA1TwoIn;
  logic [11:0]       coefTap0BOwn, rawA, rawB, filteredA, filteredB;
  logic              sdo, sdoOe, filterEnable, filterShare, filterMerged;
  logic [4:0]        gainTrimA0, gainTrimA1, gainTrimB0, gainTrimB1;
  logic signed [5:0] sideLsbExp, centerLsbExp;
  logic [11:0]       coefTap0A, coefTap0B, outA, outB;
  logic [31:0]       seed = 32'h4F, seedIn = 32'h4F, r;
  logic [7:0]        tr [6];
  logic [7:0]        cfg, tlo, thi, q;
  logic [2:0]        w;
  logic              en;
  int                errors = 0, n_compared = 0;

  fine_gain_and_pfir_config_regs u_fine_gain_and_pfir_config_regs (
    .clk(clk), .resetn(resetn), .sclk(sclk), .sdi(sdi), .csn(csn),
    .sdo(sdo), .sdoOe(sdoOe), .singleChannel(singleChannel),
    .fuseLoad(fuseLoad), .fuseTrimB0Two(fz[0]), .fuseTrimB1Two(fz[1]),
    .fuseTrimA0One(fz[2]), .fuseTrimA1One(fz[3]), .fuseTrimB0One(fz[4]),
    .fuseTrimB1One(fz[5]), .trimA0TwoIn(trimA0TwoIn),
    .trimA1TwoIn(trimA1TwoIn), .gainTrimA0(gainTrimA0),
    .gainTrimA1(gainTrimA1), .gainTrimB0(gainTrimB0),
    .gainTrimB1(gainTrimB1), .coefTap0BOwn(coefTap0BOwn),
    .filterEnable(filterEnable), .filterShare(filterShare),
    .filterMerged(filterMerged), .sideLsbExp(sideLsbExp),
    .centerLsbExp(centerLsbExp), .coefTap0A(coefTap0A),
    .coefTap0B(coefTap0B), .rawA(rawA), .rawB(rawB),
    .filteredA(filteredA), .filteredB(filteredB), .outA(outA), .outB(outB)
  );

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(inout logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // own seed here so the stream does not depend on process order
  always @(posedge clk) begin
    #1;
    {rawA, rawB} <= 24'(xs(seedIn));
    {filteredA, filteredB} <= 24'(xs(seedIn));
    {trimA0TwoIn, trimA1TwoIn, coefTap0BOwn} <= 22'(xs(seedIn));
  end

  // ==========================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    n_compared++;
    if (seen !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // sclk edges kept 3 clk apart; sdo read just before each rise
  task sbit(input logic b, output logic o);
    sclk = 0;
    sdi = b;
    cyc(3);
    o = sdo;
    sclk = 1;
    cyc(3);
  endtask

  task xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd);
    logic [15:0] h;
    logic        o;
    h = {rd, a};
    csn = 0;
    cyc(2);
    for (int i = 15; i >= 0; i--) sbit(h[i], o);
    for (int i = 7; i >= 0; i--) begin
      sbit(wd[i], o);
      q[i] = o;
    end
    sclk = 0;
    cyc(3);
    csn = 1;
    cyc(3);
  endtask

  task writeReg(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask

  task readChk(input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk($sformatf("reg %h", a), q, e);
  endtask

  task chkTrims;
    singleChannel = 0;
    @(negedge clk);
    chk("trimB0two", gainTrimB0, tr[0][4:0]);
    chk("trimB1two", gainTrimB1, tr[1][4:0]);
    cyc(1);
    singleChannel = 1;
    @(negedge clk);
    chk("trimA0one", gainTrimA0, tr[2][4:0]);
    chk("trimA1one", gainTrimA1, tr[3][4:0]);
    chk("trimB0one", gainTrimB0, tr[4][4:0]);
    chk("trimB1one", gainTrimB1, tr[5][4:0]);
    cyc(1);
  endtask

  task summarize;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial begin
    foreach (fz[i]) fz[i] = 5'h00;
    {rawA, rawB, filteredA, filteredB} = 48'h0;
    {trimA0TwoIn, trimA1TwoIn, coefTap0BOwn} = 22'h0;
    repeat (5) @(posedge clk);
    #1 resetn = 1;
    cyc(1);
    for (int i = 0; i < 6; i++) readChk(ADDR_TRIM_B0_TWO + 15'(i), 8'h00);
    readChk(ADDR_FILTER_CFG, 8'h00);
    readChk(ADDR_TAP0_A_HI, 8'h00);
    // reserved trim bits must hold what is written
    for (int i = 0; i < 6; i++) begin
      tr[i] = (i == 0) ? 8'hFF : 8'(xs(seed));
      writeReg(ADDR_TRIM_B0_TWO + 15'(i), tr[i]);
    end
    for (int i = 0; i < 6; i++) readChk(ADDR_TRIM_B0_TWO + 15'(i), tr[i]);
    chkTrims;
    for (int i = 0; i < 6; i++) begin
      fz[i] = 5'(xs(seed));
      tr[i][4:0] = fz[i];
    end
    fuseLoad = 1;
    cyc(1);
    fuseLoad = 0;
    cyc(1);
    chkTrims;
    readChk(ADDR_TRIM_B0_TWO, tr[0]);
    // every mode code, weight 6 and a negative tap as corners
    for (int k = 0; k < 12; k++) begin
      r = xs(seed);
      w = (k == 2) ? 3'h6 : 3'(r[31:24] % 7);
      // merge forced whenever one-channel mode is selected
      cfg = {r[7:6], r[5] | singleChannel, w, 2'(k)};
      tlo = r[15:8];
      thi = (k == 2) ? 8'hFF : r[23:16];
      en = (k % 4 == 2);
      writeReg(ADDR_FILTER_CFG, cfg);
      // coefficient loaded before the enabled filter is checked
      writeReg(ADDR_TAP0_A_LO, tlo);
      writeReg(ADDR_TAP0_A_HI, thi);
      cyc(2);
      chk("enable", filterEnable, en);
      chk("share", filterShare, en & cfg[6]);
      chk("merge", filterMerged, en & cfg[5]);
      chk("sideExp", sideLsbExp, en ? {3'h0, w} - 6'h10 : 6'h00);
      chk("tap0A", coefTap0A, en ? {thi[3:0], tlo} : 12'h000);
      chk("centerExp", centerLsbExp, 16'h0000);
      if (!en || cfg[6]) begin
        chk("tap0B", coefTap0B, en ? {thi[3:0], tlo} : 12'h000);
      end
      readChk(ADDR_FILTER_CFG, cfg);
      readChk(ADDR_TAP0_A_LO, tlo);
      readChk(ADDR_TAP0_A_HI, thi & 8'hF7);
    end
    writeReg(15'h0358, 8'h5A);
    readChk(ADDR_TRIM_B1_ONE, tr[5]);
    summarize;
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize;
  end
endmodule
